// *** hdl/omr_pkg.sv ***
package omr_pkg;

    localparam int OMR_ADDR_W = 8;
    localparam int OMR_DATA_W = 8;
    localparam int OMR_MODE_W = 3;

    // register offset within the bus interface block
    localparam logic [OMR_ADDR_W-1:0] OMR_OPERATING_MODE_CONTROL_OFS = 8'h0b;

    // field positions
    localparam int OMR_MODE_MSB = 7;
    localparam int OMR_MODE_LSB = 5;
    localparam int OMR_VIS_BIT = 3;
    localparam int OMR_EMK_BIT = 1;
    localparam int OMR_EME_BIT = 0;

    // mode codes
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_SPECIAL_SINGLE = 3'h0;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_EMUL_NARROW = 3'h1;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_SPECIAL_TEST = 3'h2;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_EMUL_WIDE = 3'h3;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_NORMAL_SINGLE = 3'h4;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_NORMAL_EXP_NARROW = 3'h5;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_SPECIAL_PERIPH = 3'h6;
    localparam logic [OMR_MODE_W-1:0] OMR_MODE_NORMAL_EXP_WIDE = 3'h7;

    // value driven on read data when nothing is read
    localparam logic [OMR_DATA_W-1:0] OMR_RDATA_IDLE = 8'h00;

    // register bus request
    typedef struct packed {
        logic [OMR_ADDR_W-1:0] addr;
        logic [OMR_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } omr_bus_req_type;

    // implemented register content
    typedef struct packed {
        logic [OMR_MODE_W-1:0] mode_select_field;
        logic internal_visibility;
        logic emulate_port_k;
        logic emulate_port_e;
    } omr_bits_type;

    // decoded map state driven to the rest of the chip
    typedef struct packed {
        logic internal_visibility;
        logic port_k_regs_mapped;
        logic port_e_regs_mapped;
        logic mode_reg_mapped;
    } omr_map_type;

endpackage : omr_pkg

// *** hdl/omr_top.sv ***
// Implementation choice: the plain strobed port.
module omr_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // mode strap read while reset is high, secured read when a staged write applies
    input wire logic [omr_pkg::OMR_MODE_W-1:0] mode_strap,
    input wire logic secured,
    // register bus
    input wire omr_pkg::omr_bus_req_type bus_req,
    output logic [omr_pkg::OMR_DATA_W-1:0] bus_rdata,
    // system side
    output logic [omr_pkg::OMR_MODE_W-1:0] mode_out,
    output omr_pkg::omr_map_type map_out,
    output logic ext_echo
);
    import omr_pkg::*;

    function automatic logic is_special(input logic [OMR_MODE_W-1:0] m);
        is_special = (m[2] == 1'b0 && m[0] == 1'b0) || (m == OMR_MODE_SPECIAL_PERIPH);
    endfunction : is_special

    function automatic logic is_emul(input logic [OMR_MODE_W-1:0] m);
        is_emul = (m == OMR_MODE_EMUL_NARROW) || (m == OMR_MODE_EMUL_WIDE);
    endfunction : is_emul

    function automatic logic is_single(input logic [OMR_MODE_W-1:0] m);
        is_single = (m == OMR_MODE_SPECIAL_SINGLE) || (m == OMR_MODE_NORMAL_SINGLE);
    endfunction : is_single

    function automatic logic is_periph(input logic [OMR_MODE_W-1:0] m);
        is_periph = (m == OMR_MODE_SPECIAL_PERIPH);
    endfunction : is_periph

    // register reachable on chip: not expanded, not peripheral
    function automatic logic reg_mapped(input logic [OMR_MODE_W-1:0] m);
        reg_mapped = (m[0] == 1'b0) && !is_periph(m);
    endfunction : reg_mapped

    // write permission class of one bit in the current mode
    typedef enum logic [1:0] {
        PERM_ANYTIME,
        PERM_ONCE,
        PERM_NEVER
    } omr_perm_type;

    // mode field: free in special single chip and special test, once in normal single chip
    function automatic omr_perm_type perm_mode(input logic [OMR_MODE_W-1:0] m);
        perm_mode = PERM_NEVER;
        unique case (m)
            OMR_MODE_SPECIAL_SINGLE: perm_mode = PERM_ANYTIME;
            OMR_MODE_EMUL_NARROW: perm_mode = PERM_NEVER;
            OMR_MODE_SPECIAL_TEST: perm_mode = PERM_ANYTIME;
            OMR_MODE_EMUL_WIDE: perm_mode = PERM_NEVER;
            OMR_MODE_NORMAL_SINGLE: perm_mode = PERM_ONCE;
            OMR_MODE_NORMAL_EXP_NARROW: perm_mode = PERM_NEVER;
            OMR_MODE_SPECIAL_PERIPH: perm_mode = PERM_NEVER;
            OMR_MODE_NORMAL_EXP_WIDE: perm_mode = PERM_NEVER;
        endcase
    endfunction : perm_mode

    // visibility bit: once normal, never emulation, anytime special
    function automatic omr_perm_type perm_vis(input logic [OMR_MODE_W-1:0] m);
        perm_vis = PERM_NEVER;
        unique case (m)
            OMR_MODE_SPECIAL_SINGLE: perm_vis = PERM_ANYTIME;
            OMR_MODE_EMUL_NARROW: perm_vis = PERM_NEVER;
            OMR_MODE_SPECIAL_TEST: perm_vis = PERM_ANYTIME;
            OMR_MODE_EMUL_WIDE: perm_vis = PERM_NEVER;
            OMR_MODE_NORMAL_SINGLE: perm_vis = PERM_ONCE;
            OMR_MODE_NORMAL_EXP_NARROW: perm_vis = PERM_ONCE;
            OMR_MODE_SPECIAL_PERIPH: perm_vis = PERM_ANYTIME;
            OMR_MODE_NORMAL_EXP_WIDE: perm_vis = PERM_ONCE;
        endcase
    endfunction : perm_vis

    // port k bit follows the visibility bit
    function automatic omr_perm_type perm_emk(input logic [OMR_MODE_W-1:0] m);
        perm_emk = perm_vis(m);
    endfunction : perm_emk

    // port e bit: special modes only
    function automatic omr_perm_type perm_eme(input logic [OMR_MODE_W-1:0] m);
        perm_eme = PERM_NEVER;
        unique case (m)
            OMR_MODE_SPECIAL_SINGLE: perm_eme = PERM_ANYTIME;
            OMR_MODE_EMUL_NARROW: perm_eme = PERM_NEVER;
            OMR_MODE_SPECIAL_TEST: perm_eme = PERM_ANYTIME;
            OMR_MODE_EMUL_WIDE: perm_eme = PERM_NEVER;
            OMR_MODE_NORMAL_SINGLE: perm_eme = PERM_NEVER;
            OMR_MODE_NORMAL_EXP_NARROW: perm_eme = PERM_NEVER;
            OMR_MODE_SPECIAL_PERIPH: perm_eme = PERM_ANYTIME;
            OMR_MODE_NORMAL_EXP_WIDE: perm_eme = PERM_NEVER;
        endcase
    endfunction : perm_eme

    // strap dependent reset content; peripheral mode is reset though unreachable
    function automatic omr_bits_type reset_bits(input logic [OMR_MODE_W-1:0] m);
        reset_bits = '0;
        reset_bits.mode_select_field = m;
        unique case (m)
            OMR_MODE_SPECIAL_SINGLE: begin
                reset_bits.internal_visibility = 1'b0;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
            OMR_MODE_EMUL_NARROW: begin
                reset_bits.internal_visibility = 1'b1;
                reset_bits.emulate_port_k = 1'b1;
                reset_bits.emulate_port_e = 1'b1;
            end
            OMR_MODE_SPECIAL_TEST: begin
                reset_bits.internal_visibility = 1'b1;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
            OMR_MODE_EMUL_WIDE: begin
                reset_bits.internal_visibility = 1'b1;
                reset_bits.emulate_port_k = 1'b1;
                reset_bits.emulate_port_e = 1'b1;
            end
            OMR_MODE_NORMAL_SINGLE: begin
                reset_bits.internal_visibility = 1'b0;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
            OMR_MODE_NORMAL_EXP_NARROW: begin
                reset_bits.internal_visibility = 1'b0;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
            OMR_MODE_SPECIAL_PERIPH: begin
                reset_bits.internal_visibility = 1'b0;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
            OMR_MODE_NORMAL_EXP_WIDE: begin
                reset_bits.internal_visibility = 1'b0;
                reset_bits.emulate_port_k = 1'b0;
                reset_bits.emulate_port_e = 1'b0;
            end
        endcase
    endfunction : reset_bits

    // map state seen by the rest of the chip for one register value
    function automatic omr_map_type decode_map(input omr_bits_type b);
        logic [OMR_MODE_W-1:0] m;
        m = b.mode_select_field;
        decode_map.internal_visibility = b.internal_visibility;
        decode_map.port_k_regs_mapped = is_single(m) ||
            (!is_periph(m) && !b.emulate_port_k);
        decode_map.port_e_regs_mapped = is_single(m) || !b.emulate_port_e;
        decode_map.mode_reg_mapped = reg_mapped(m);
    endfunction : decode_map

    // register state
    omr_bits_type bits_ff, nxt_bits;
    logic once_mode_ff, nxt_once_mode;
    logic once_vis_ff, nxt_once_vis;
    logic once_emk_ff, nxt_once_emk;
    // delayed write
    logic pend_ff, nxt_pend;
    logic [OMR_DATA_W-1:0] pend_data_ff, nxt_pend_data;
    // outputs
    logic [OMR_DATA_W-1:0] rdata_ff, nxt_rdata;
    logic [OMR_MODE_W-1:0] mode_out_ff, nxt_mode_out;
    omr_map_type map_ff, nxt_map;
    logic echo_ff, nxt_echo;

    // bus group: stage writes, answer reads, echo off-map accesses
    always_comb begin
        logic hit;
        logic on_chip;
        hit = (bus_req.addr == OMR_OPERATING_MODE_CONTROL_OFS);
        on_chip = reg_mapped(bits_ff.mode_select_field);
        nxt_pend = 1'b0;
        nxt_pend_data = pend_data_ff;
        nxt_rdata = OMR_RDATA_IDLE;
        nxt_echo = 1'b0;
        // stage the write; it is judged against the state of the apply cycle
        if (bus_req.wr && hit && on_chip) begin
            nxt_pend = 1'b1;
            nxt_pend_data = bus_req.wdata;
        end
        if ((bus_req.wr || bus_req.rd) && hit && !on_chip) begin
            nxt_echo = 1'b1;
        end
        if (bus_req.rd && hit && on_chip) begin
            // unimplemented bits stay zero
            nxt_rdata = {bits_ff.mode_select_field, 1'b0, bits_ff.internal_visibility,
                         1'b0, bits_ff.emulate_port_k, bits_ff.emulate_port_e};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
            pend_data_ff <= OMR_RDATA_IDLE;
            rdata_ff <= OMR_RDATA_IDLE;
            echo_ff <= 1'b0;
        end else begin
            pend_ff <= nxt_pend;
            pend_data_ff <= nxt_pend_data;
            rdata_ff <= nxt_rdata;
            echo_ff <= nxt_echo;
        end
    end

    // register group: the staged write lands one cycle after its strobe
    always_comb begin
        logic [OMR_MODE_W-1:0] cur;
        logic [OMR_MODE_W-1:0] req;
        omr_perm_type mode_perm;
        omr_perm_type vis_perm;
        omr_perm_type emk_perm;
        omr_perm_type eme_perm;
        cur = bits_ff.mode_select_field;
        req = pend_data_ff[OMR_MODE_MSB:OMR_MODE_LSB];
        mode_perm = perm_mode(cur);
        vis_perm = perm_vis(cur);
        emk_perm = perm_emk(cur);
        eme_perm = perm_eme(cur);
        nxt_bits = bits_ff;
        nxt_once_mode = once_mode_ff;
        nxt_once_vis = once_vis_ff;
        nxt_once_emk = once_emk_ff;
        if (pend_ff) begin
            // mode field; secured locks it whatever the mode
            if (secured) begin
                nxt_bits.mode_select_field = cur;
            end else begin
                unique case (mode_perm)
                    PERM_ANYTIME: begin
                        // leaving 110 cannot happen here, entering it is refused
                        if (req != OMR_MODE_SPECIAL_PERIPH) begin
                            nxt_bits.mode_select_field = req;
                            if (req == OMR_MODE_NORMAL_SINGLE) begin
                                // one further write stays available
                                nxt_once_mode = 1'b0;
                                nxt_once_vis = 1'b0;
                                nxt_once_emk = 1'b0;
                            end else if (!is_special(req)) begin
                                nxt_once_mode = 1'b1;
                                nxt_once_vis = 1'b1;
                                nxt_once_emk = 1'b1;
                            end
                        end
                    end
                    PERM_ONCE: begin
                        if (!once_mode_ff) begin
                            // top bit never moves; a refused target still uses the one write
                            nxt_once_mode = 1'b1;
                            if (req == OMR_MODE_NORMAL_EXP_NARROW ||
                                req == OMR_MODE_NORMAL_EXP_WIDE) begin
                                nxt_bits.mode_select_field = {cur[2], req[1:0]};
                            end
                        end
                    end
                    PERM_NEVER: begin
                        // low mode bit set, or peripheral: field frozen
                        nxt_bits.mode_select_field = cur;
                    end
                endcase
            end
            // visibility bit
            unique case (vis_perm)
                PERM_ANYTIME: begin
                    nxt_bits.internal_visibility = pend_data_ff[OMR_VIS_BIT];
                end
                PERM_ONCE: begin
                    if (!once_vis_ff) begin
                        nxt_bits.internal_visibility = pend_data_ff[OMR_VIS_BIT];
                        nxt_once_vis = 1'b1;
                    end
                end
                PERM_NEVER: begin
                end
            endcase
            // port k bit
            unique case (emk_perm)
                PERM_ANYTIME: begin
                    nxt_bits.emulate_port_k = pend_data_ff[OMR_EMK_BIT];
                end
                PERM_ONCE: begin
                    if (!once_emk_ff) begin
                        nxt_bits.emulate_port_k = pend_data_ff[OMR_EMK_BIT];
                        nxt_once_emk = 1'b1;
                    end
                end
                PERM_NEVER: begin
                end
            endcase
            // port e bit
            unique case (eme_perm)
                PERM_ANYTIME: begin
                    nxt_bits.emulate_port_e = pend_data_ff[OMR_EME_BIT];
                end
                PERM_ONCE, PERM_NEVER: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // sync reset, so the strap level can be taken here
            bits_ff <= reset_bits(mode_strap);
            once_mode_ff <= 1'b0;
            once_vis_ff <= 1'b0;
            once_emk_ff <= 1'b0;
        end else begin
            bits_ff <= nxt_bits;
            once_mode_ff <= nxt_once_mode;
            once_vis_ff <= nxt_once_vis;
            once_emk_ff <= nxt_once_emk;
        end
    end

    // output group: decoded from the next value so outputs track the register
    always_comb begin
        nxt_mode_out = nxt_bits.mode_select_field;
        nxt_map = decode_map(nxt_bits);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_out_ff <= mode_strap;
            map_ff <= decode_map(reset_bits(mode_strap));
        end else begin
            mode_out_ff <= nxt_mode_out;
            map_ff <= nxt_map;
        end
    end

    assign bus_rdata = rdata_ff;
    assign mode_out = mode_out_ff;
    assign map_out = map_ff;
    assign ext_echo = echo_ff;

endmodule : omr_top

// *** tb/omr_top_props.sv ***
module omr_top_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // inputs
    input wire logic [omr_pkg::OMR_MODE_W-1:0] mode_strap,
    input wire logic secured,
    input wire omr_pkg::omr_bus_req_type bus_req,
    // outputs
    input wire logic [omr_pkg::OMR_DATA_W-1:0] bus_rdata,
    input wire logic [omr_pkg::OMR_MODE_W-1:0] mode_out,
    input wire omr_pkg::omr_map_type map_out,
    input wire logic ext_echo
);
    import omr_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic hit;
    assign hit = (bus_req.wr | bus_req.rd) && bus_req.addr == OMR_OPERATING_MODE_CONTROL_OFS;
    property p_rsvd; bus_rdata[4] == 1'b0 && bus_rdata[2] == 1'b0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_rd;
        hit && bus_req.rd && map_out.mode_reg_mapped |=>
            bus_rdata[7:5] == $past(mode_out) && bus_rdata[3] == $past(map_out.internal_visibility);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_echo; hit && !map_out.mode_reg_mapped |=> ext_echo && bus_rdata == 8'h00; endproperty
    a_echo: assert property (p_echo) else $error("no external echo");
    property p_map;
        map_out.mode_reg_mapped == (mode_out == 3'h0 || mode_out == 3'h2 || mode_out == 3'h4);
    endproperty
    a_map: assert property (p_map) else $error("map state wrong");
    property p_lock; mode_out[0] |=> $stable(mode_out); endproperty
    a_lock: assert property (p_lock) else $error("locked mode changed");
    property p_sec; secured |=> $stable(mode_out); endproperty
    a_sec: assert property (p_sec) else $error("mode changed while secured");
    property p_periph; 1'b1 |=> (mode_out == 3'h6) == $past(mode_out == 3'h6); endproperty
    a_periph: assert property (p_periph) else $error("peripheral code crossed");
    property p_delay; hit && bus_req.wr && !$past(bus_req.wr) |=> $stable(mode_out); endproperty
    a_delay: assert property (p_delay) else $error("write applied too early");
    // single chip keeps both port blocks in the map
    property p_single;
        mode_out == 3'h0 || mode_out == 3'h4 |->
            map_out.port_k_regs_mapped && map_out.port_e_regs_mapped;
    endproperty
    a_single: assert property (p_single) else $error("port regs unmapped");
    c_change: cover property (hit && bus_req.wr ##2 $changed(mode_out));
    c_echo: cover property (ext_echo);
    c_sec: cover property (secured && hit && bus_req.wr);
endmodule : omr_top_props

bind omr_top omr_top_props u_props (.ref_clk, .rst, .mode_strap, .secured, .bus_req,
    .bus_rdata, .mode_out, .map_out, .ext_echo);

// *** tb/omr_tb_top.sv ***
module omr_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import omr_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mode_strap = 3'h0;
    logic secured = 1'b0;
    omr_bus_req_type bus_req = '0;
    logic [7:0] bus_rdata;
    logic [2:0] mode_out;
    omr_map_type map_out;
    logic ext_echo;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [7:0] MA = OMR_OPERATING_MODE_CONTROL_OFS;
    omr_top dut (.ref_clk, .rst, .mode_strap, .secured, .bus_req, .bus_rdata, .mode_out,
        .map_out, .ext_echo);
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic [2:0] m);
        @(posedge ref_clk);
        rst <= 1'b1;
        mode_strap <= m;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : do_reset
    // one strobe cycle, returns just after the strobe edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
    endtask : bus
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic echo);
        bus(1'b0, a, 8'h00);
        chk(bus_rdata, exp);
        chk({7'h0, ext_echo}, {7'h0, echo});
    endtask : rd_chk
    task automatic t_reset();
        logic [7:0] e;
        logic on;
        logic emul;
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i));
            on = (i == 0 || i == 2 || i == 4);
            emul = (i == 1 || i == 3);
            e = {3'(i), 1'b0, (i >= 1 && i <= 3), 1'b0, emul, emul};
            chk({5'h0, mode_out}, 8'(i));
            chk({4'h0, map_out}, {4'h0, i >= 1 && i <= 3, !emul && i != 6, !emul, on});
            rd_chk(MA, on ? e : 8'h00, !on);
        end
        $display("test reset done");
    endtask : t_reset
    task automatic t_special();
        do_reset(3'h0);
        bus(1'b1, MA, 8'h5f);
        rd_chk(MA, 8'h4b, 1'b0);
        chk({4'h0, map_out}, 8'h09);
        bus(1'b1, MA, 8'hcb);
        rd_chk(MA, 8'h4b, 1'b0);
        bus(1'b1, MA, 8'h00);
        rd_chk(MA, 8'h00, 1'b0);
        $display("test special done");
    endtask : t_special
    task automatic t_to_normal();
        do_reset(3'h2);
        bus(1'b1, MA, 8'h80);
        rd_chk(MA, 8'h80, 1'b0);
        bus(1'b1, MA, 8'ha8);
        @(posedge ref_clk);
        #1;
        chk({5'h0, mode_out}, 8'h05);
        chk({7'h0, map_out.internal_visibility}, 8'h01);
        rd_chk(MA, 8'h00, 1'b1);
        $display("test to normal done");
    endtask : t_to_normal
    task automatic t_normal();
        do_reset(3'h4);
        bus(1'b1, MA, 8'h8b);
        rd_chk(MA, 8'h8a, 1'b0);
        bus(1'b1, MA, 8'he0);
        rd_chk(MA, 8'h8a, 1'b0);
        $display("test normal done");
    endtask : t_normal
    task automatic t_secure();
        do_reset(3'h0);
        secured <= 1'b1;
        bus(1'b1, MA, 8'h40);
        @(posedge ref_clk);
        secured <= 1'b0;
        #1;
        chk({5'h0, mode_out}, 8'h00);
        bus(1'b1, MA, 8'h40);
        chk({5'h0, mode_out}, 8'h00);
        @(posedge ref_clk);
        #1;
        chk({5'h0, mode_out}, 8'h02);
        bus(1'b1, 8'h0c, 8'h00);
        rd_chk(8'h0c, 8'h00, 1'b0);
        chk({5'h0, mode_out}, 8'h02);
        $display("test secure done");
    endtask : t_secure
    initial begin
        t_reset();
        t_special();
        t_to_normal();
        t_normal();
        t_secure();
        print_verdict();
    end
endmodule : omr_tb_top
